// *** shared/split_pkg.sv ***
// Purpose: constants and types shared by the memory split decoder ends
// Assumes: byte-wide I/O registers, 32-bit memory addresses
// Notes:   host register offsets are byte addresses on AXI4-Lite
package split_pkg;
  // ---------------------------------------------------------------
  // device I/O registers
  // ---------------------------------------------------------------
  localparam logic [15:0] SPLIT_BASE_OFS = 16'h00e0;
  localparam logic [15:0] ENCODING_OFS   = 16'h00e1;
  localparam logic [7:0]  BASE_RESET     = 8'h00;
  localparam logic [7:0]  ENC_RESET      = 8'h0e;
  localparam logic [7:0]  BASE_MASK      = 8'h0f;
  localparam logic [7:0]  IO_UNMAPPED    = 8'hff;
  localparam int          RELOC_DIS_BIT  = 3;
  localparam int          LOW512_BIT     = 2;
  localparam int          ROM_KEEP_BIT   = 1;
  // ---------------------------------------------------------------
  // memory map boundaries
  // ---------------------------------------------------------------
  localparam logic [31:0] LOW512_END     = 32'h00080000;
  localparam logic [31:0] VIDEO_START    = 32'h000a0000;
  localparam logic [31:0] CHROM_START    = 32'h000c0000;
  localparam logic [31:0] ROM_START      = 32'h000e0000;
  localparam logic [31:0] ONE_MB         = 32'h00100000;
  localparam logic [31:0] TOP_ROM_START  = 32'hfffe0000;
  localparam logic [19:0] SPLIT_384K     = 20'h60000;
  localparam logic [19:0] SPLIT_512K     = 20'h80000;
  localparam logic [3:0]  BASE_MAX       = 4'hf;
  // ---------------------------------------------------------------
  // controller registers on AXI4-Lite
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  ADDR_OFS       = 8'h04;
  localparam logic [7:0]  WDATA_OFS      = 8'h08;
  localparam logic [7:0]  STATUS_OFS     = 8'h0c;
  localparam int          CTRL_GO_BIT    = 0;
  localparam int          CTRL_IO_BIT    = 1;
  localparam int          CTRL_WR_BIT    = 2;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [3:0] {
    TGT_NONE, TGT_LOW_RAM, TGT_VIDEO, TGT_CHAN_ROM, TGT_BOARD_ROM,
    TGT_ROMSPACE_RAM, TGT_EXT_RAM, TGT_CHAN_RAM, TGT_SPLIT_RAM
  } target_e;
endpackage

// *** shared/mem_cycle_if.sv ***
// Purpose: processor cycle carrier between controller and decoder
// Assumes: both ends on aclk; one cycle under way at a time
// Notes:   answer is a one-cycle pulse, one cycle after the request
`timescale 1ns/10ps
interface mem_cycle_if;
  import split_pkg::*;
  logic        cyc_valid;  // request pulse
  logic        cyc_io;     // 1 = I/O cycle, 0 = memory cycle
  logic        cyc_write;  // 1 = write
  logic [31:0] cyc_addr;   // memory address or I/O port in [15:0]
  logic [7:0]  cyc_wdata;  // I/O write data
  logic        ans_valid;  // answer pulse
  logic [7:0]  ans_rdata;  // I/O read data
  target_e     ans_target; // decoded memory target

  modport proc  (output cyc_valid, cyc_io, cyc_write, cyc_addr,
                 cyc_wdata, input ans_valid, ans_rdata, ans_target);
  modport board (input cyc_valid, cyc_io, cyc_write, cyc_addr,
                 cyc_wdata, output ans_valid, ans_rdata, ans_target);
endinterface

// *** logic/axil_regs.sv ***
// Purpose: AXI4-Lite slave holding the controller's own registers
// Assumes: one write and one read under way at a time
// Notes:   go is a one-cycle pulse; unmapped offsets answer SLVERR
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
module axil_regs (
  input  wire logic        aclk,          // system clock
  input  wire logic        aresetn,       // sync reset, active low
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // byte enables
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  output logic [1:0]       s_axi_bresp,   // write response
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             go,            // command start pulse
  output logic [2:0]       ctrl,          // stored command bits
  output logic [31:0]      cmd_addr,      // stored cycle address
  output logic [7:0]       cmd_wdata,     // stored write data
  input  wire logic [31:0] status         // status word to read
);
  import split_pkg::*;
  logic        aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [7:0]  aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0]  w_strb_reg, w_strb_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next, addr_reg, addr_next;
  logic [2:0]  ctrl_reg, ctrl_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic        go_reg, go_next;

  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready  = !w_got_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign go            = go_reg;
  assign ctrl          = ctrl_reg;
  assign cmd_addr      = addr_reg;
  assign cmd_wdata     = wdata_reg;

  // channel capture, register writes and read answers
  always_comb begin
    aw_got_next = aw_got_reg;
    aw_addr_next = aw_addr_reg;
    w_got_next = w_got_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !s_axi_rready;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    addr_next = addr_reg;
    ctrl_next = ctrl_reg;
    wdata_next = wdata_reg;
    go_next = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (aw_got_reg && w_got_reg) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      case (aw_addr_reg)
        CTRL_OFS: if (w_strb_reg[0]) begin
          ctrl_next = w_data_reg[2:0];
          go_next = w_data_reg[CTRL_GO_BIT];
        end
        ADDR_OFS: for (int i = 0; i < 4; i++) begin
          if (w_strb_reg[i]) addr_next[i*8 +: 8] = w_data_reg[i*8 +: 8];
        end
        WDATA_OFS: if (w_strb_reg[0]) wdata_next = w_data_reg[7:0];
        STATUS_OFS: bresp_next = RESP_OKAY;
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case (s_axi_araddr)
        CTRL_OFS:   rdata_next = {29'h0, ctrl_reg};
        ADDR_OFS:   rdata_next = addr_reg;
        WDATA_OFS:  rdata_next = {24'h0, wdata_reg};
        STATUS_OFS: rdata_next = status;
        default: begin
          rdata_next = 32'h0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end

  // register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      aw_addr_reg <= 8'h0;
      w_got_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0;
      addr_reg <= 32'h0;
      ctrl_reg <= 3'h0;
      wdata_reg <= 8'h0;
      go_reg <= 1'b0;
    end else begin
      aw_got_reg <= aw_got_next;
      aw_addr_reg <= aw_addr_next;
      w_got_reg <= w_got_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      addr_reg <= addr_next;
      ctrl_reg <= ctrl_next;
      wdata_reg <= wdata_next;
      go_reg <= go_next;
    end
  end
endmodule

// *** logic/split_controller.sv ***
// Purpose: processor-side end issuing I/O and memory cycles
// Assumes: software orders cycles through axil_regs
// Notes:   refuses register writes that the decoder cannot accept, except an encoding write that enables relocation while the base is 0
`timescale 1ns/10ps
module split_controller (
  input  wire logic        aclk,          // system clock
  input  wire logic        aresetn,       // sync reset, active low
  mem_cycle_if.proc        bus,           // link to the decoder
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // byte enables
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  output logic [1:0]       s_axi_bresp,   // write response
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  input  wire logic        mem_16m_or_more // memory reaches 16M
);
  import split_pkg::*;
  typedef enum logic {H_IDLE, H_WAIT} hstate_e;
  hstate_e     st_reg, st_next;
  logic        go;
  logic [2:0]  ctrl;
  logic [31:0] cmd_addr, status;
  logic [7:0]  cmd_wdata, wr_val, enc_reg, enc_next;
  logic        done_reg, done_next, refused_reg, refused_next;
  logic        valid_reg, valid_next, io_reg, io_next, wr_reg, wr_next;
  logic [31:0] addr_reg, addr_next;
  logic [7:0]  wd_reg, wd_next, rd_reg, rd_next;
  target_e     tgt_reg, tgt_next;
  logic        is_base, is_enc, bad;

  axil_regs axil_regs_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .go(go), .ctrl(ctrl),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .status(status)
  );

  assign status = {12'h0, tgt_reg, rd_reg, 4'h0, enc_reg[RELOC_DIS_BIT],
                   refused_reg, done_reg, st_reg == H_WAIT};
  assign bus.cyc_valid = valid_reg;
  assign bus.cyc_io    = io_reg;
  assign bus.cyc_write = wr_reg;
  assign bus.cyc_addr  = addr_reg;
  assign bus.cyc_wdata = wd_reg;

  // write screening against the decoder's known settings
  always_comb begin
    is_base = ctrl[CTRL_IO_BIT] && ctrl[CTRL_WR_BIT]
              && cmd_addr[15:0] == SPLIT_BASE_OFS;
    is_enc  = ctrl[CTRL_IO_BIT] && ctrl[CTRL_WR_BIT]
              && cmd_addr[15:0] == ENCODING_OFS;
    wr_val = cmd_wdata;
    if (is_base) wr_val = cmd_wdata & BASE_MASK;
    if (is_enc && mem_16m_or_more)
      wr_val[RELOC_DIS_BIT] = 1'b1;
    bad = 1'b0;
    if (is_base && !enc_reg[RELOC_DIS_BIT] && wr_val[3:0] == 4'h0)
      bad = 1'b1;
    if (is_enc && !wr_val[RELOC_DIS_BIT] && !wr_val[ROM_KEEP_BIT])
      bad = 1'b1;
  end

  // command sequencing and result capture
  always_comb begin
    st_next = st_reg;
    valid_next = 1'b0;
    io_next = io_reg;
    wr_next = wr_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    tgt_next = tgt_reg;
    enc_next = enc_reg;
    done_next = done_reg;
    refused_next = refused_reg;
    case (st_reg)
      H_IDLE: if (go) begin
        done_next = 1'b0;
        refused_next = bad;
        if (!bad) begin
          valid_next = 1'b1;
          io_next = ctrl[CTRL_IO_BIT];
          wr_next = ctrl[CTRL_WR_BIT];
          addr_next = cmd_addr;
          wd_next = wr_val;
          if (is_enc) enc_next = wr_val;
          st_next = H_WAIT;
        end
      end
      H_WAIT: if (bus.ans_valid) begin
        rd_next = bus.ans_rdata;
        tgt_next = bus.ans_target;
        done_next = 1'b1;
        st_next = H_IDLE;
      end
      default: st_next = H_IDLE;
    endcase
  end

  // register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= H_IDLE;
      valid_reg <= 1'b0;
      io_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= 32'h0;
      wd_reg <= 8'h0;
      rd_reg <= 8'h0;
      tgt_reg <= TGT_NONE;
      enc_reg <= ENC_RESET;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      valid_reg <= valid_next;
      io_reg <= io_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      tgt_reg <= tgt_next;
      enc_reg <= enc_next;
      done_reg <= done_next;
      refused_reg <= refused_next;
    end
  end
endmodule

// *** logic/board_memory_split_decoder.sv ***
// Purpose: board memory address decoder with split relocation
// Assumes: one cycle at a time from the controller; X and Y strapped
// Notes:   answers every cycle one clock after taking it
`timescale 1ns/10ps
module board_memory_split_decoder (
  input  wire logic       aclk,           // system clock
  input  wire logic       aresetn,        // sync reset, active low
  mem_cycle_if.board      bus,            // processor cycles
  input  wire logic       board_ext_mb,   // X: extra 1M board RAM
  input  wire logic [3:0] channel_mb,     // Y: channel RAM megabytes
  output logic            split_active,   // relocation in force
  output logic            config_invalid  // forbidden settings held
);
  import split_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] base_reg, base_next;
  logic [7:0] enc_reg, enc_next;
  logic       ans_valid_reg, ans_valid_next;
  logic [7:0] ans_rdata_reg, ans_rdata_next;
  target_e    ans_target_reg, ans_target_next;
  logic       active_reg, active_next;
  logic       invalid_reg, invalid_next;
  logic       relocation_disable, low_split_512, rom_keep;
  logic       reloc_on;
  target_e    decoded;

  assign relocation_disable = enc_reg[RELOC_DIS_BIT];
  assign low_split_512      = enc_reg[LOW512_BIT];
  assign rom_keep           = enc_reg[ROM_KEEP_BIT];
  assign bus.ans_valid      = ans_valid_reg;
  assign bus.ans_rdata      = ans_rdata_reg;
  assign bus.ans_target     = ans_target_reg;
  assign split_active       = active_reg;
  assign config_invalid     = invalid_reg;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // maps one address to exactly one target
  function automatic target_e decode_addr(
    input logic [31:0] a,
    input logic [3:0]  base,
    input logic        reloc,
    input logic        sel512,
    input logic        keep,
    input logic        x,
    input logic [3:0]  y
  );
    logic [11:0] mb;
    logic [11:0] ext_end;
    logic [11:0] chan_end;
    logic [19:0] span;
    target_e     t;
    mb = a[31:20];
    ext_end = 12'd1 + {11'h0, x};
    chan_end = ext_end + {8'h0, y};
    span = sel512 ? SPLIT_512K : SPLIT_384K;
    t = TGT_NONE;
    if (a < ONE_MB) begin
      if (a < LOW512_END) t = TGT_LOW_RAM;
      else if (a < VIDEO_START) t = sel512 ? TGT_NONE : TGT_LOW_RAM;
      else if (a < CHROM_START) t = TGT_VIDEO;
      else if (a < ROM_START) t = TGT_CHAN_ROM;
      else if (keep) t = TGT_BOARD_ROM;
      else t = TGT_ROMSPACE_RAM;
    end else if (a >= TOP_ROM_START) begin
      t = TGT_BOARD_ROM;
    end else if (mb < ext_end) begin
      t = TGT_EXT_RAM;
    end else if (mb < chan_end) begin
      t = TGT_CHAN_RAM;
    end else if (reloc && mb == {8'h0, base} && a[19:0] < span) begin
      t = TGT_SPLIT_RAM;
    end
    return t;
  endfunction

  // relocation only with a legal, nonzero base
  always_comb begin
    reloc_on = !relocation_disable && rom_keep
               && base_reg[3:0] != 4'h0;
    decoded = decode_addr(bus.cyc_addr, base_reg[3:0], reloc_on,
                          low_split_512, rom_keep, board_ext_mb,
                          channel_mb);
  end

  // ---------------------------------------------------------------
  // cycle handling
  // ---------------------------------------------------------------
  // I/O register access and memory answer
  always_comb begin
    base_next = base_reg;
    enc_next = enc_reg;
    ans_valid_next = 1'b0;
    ans_rdata_next = ans_rdata_reg;
    ans_target_next = ans_target_reg;
    if (bus.cyc_valid) begin
      ans_valid_next = 1'b1;
      ans_target_next = TGT_NONE;
      ans_rdata_next = 8'h00;
      if (bus.cyc_io) begin
        case (bus.cyc_addr[15:0])
          SPLIT_BASE_OFS: begin
            if (bus.cyc_write) base_next = bus.cyc_wdata;
            else ans_rdata_next = base_reg;
          end
          ENCODING_OFS: begin
            if (bus.cyc_write) enc_next = bus.cyc_wdata;
            else ans_rdata_next = enc_reg;
          end
          default: ans_rdata_next = IO_UNMAPPED;
        endcase
      end else begin
        ans_target_next = decoded;
      end
    end
  end

  // status flags from current settings
  always_comb begin
    active_next = reloc_on;
    invalid_next = (!relocation_disable && !rom_keep)
                   || (!relocation_disable
                       && base_reg[3:0] == 4'h0);
  end

  // ---------------------------------------------------------------
  // register stage
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_reg <= BASE_RESET;
      enc_reg <= ENC_RESET;
      ans_valid_reg <= 1'b0;
      ans_rdata_reg <= 8'h00;
      ans_target_reg <= TGT_NONE;
      active_reg <= 1'b0;
      invalid_reg <= 1'b0;
    end else begin
      base_reg <= base_next;
      enc_reg <= enc_next;
      ans_valid_reg <= ans_valid_next;
      ans_rdata_reg <= ans_rdata_next;
      ans_target_reg <= ans_target_next;
      active_reg <= active_next;
      invalid_reg <= invalid_next;
    end
  end
endmodule

// *** tb/split_chk.sv ***
// Purpose: link checks between controller and split decoder
// Assumes: one clock domain, synchronous active-low reset
// Notes:   watches the cycle carrier signals only
`timescale 1ns/10ps
module split_chk (
  input wire logic               aclk,       // clock
  input wire logic               aresetn,    // reset, low
  input wire logic               cyc_valid,  // request
  input wire logic               cyc_io,     // io cycle
  input wire logic [31:0]        cyc_addr,   // address
  input wire logic               ans_valid,  // answer
  input wire logic [7:0]         ans_rdata,  // read data
  input wire split_pkg::target_e ans_target  // decoded target
);
  import split_pkg::*;
  // memory request and its 128K block number
  wire logic        mem_req = cyc_valid & ~cyc_io;
  wire logic [14:0] blk     = cyc_addr[31:17];
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_ANSWER: assert property (cyc_valid |=> ans_valid ##1 !ans_valid)
    else $error("answer pulse wrong");
  AST_NO_STRAY: assert property (ans_valid |-> $past(cyc_valid))
    else $error("answer without request");
  AST_LOW: assert property (mem_req && blk < 15'h4 |=>
    ans_target == TGT_LOW_RAM) else $error("low ram miss");
  AST_VIDEO: assert property (mem_req && blk == 15'h5 |=>
    ans_target == TGT_VIDEO) else $error("video miss");
  AST_CHROM: assert property (mem_req && blk == 15'h6 |=>
    ans_target == TGT_CHAN_ROM) else $error("channel rom miss");
  AST_ROMSPACE: assert property (mem_req && blk == 15'h7 |=>
    ans_target inside {TGT_BOARD_ROM, TGT_ROMSPACE_RAM})
    else $error("rom space miss");
  AST_TOP_ROM: assert property (mem_req && blk == 15'h7fff |=>
    ans_target == TGT_BOARD_ROM) else $error("top rom miss");
  AST_IO_NONE: assert property (cyc_valid && cyc_io |=>
    ans_target == TGT_NONE) else $error("io cycle has target");
  AST_MEM_RDATA: assert property (mem_req |=> ans_rdata == 8'h00)
    else $error("memory cycle read data");
endmodule

// *** tb/tb_top.sv ***
// Purpose: bench for the split controller and decoder pair
// Assumes: controller register map of split_pkg
// Notes:   board straps X and Y driven by the bench
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("Error %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import split_pkg::*;
  localparam logic [31:0] BASE = {16'h0, SPLIT_BASE_OFS};
  localparam logic [31:0] ENC  = {16'h0, ENCODING_OFS};
  logic        aclk;
  logic        aresetn = 1'b0, board_ext_mb = 1'b1, mem_16m_or_more = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, st;
  logic [3:0]  s_axi_wstrb = 4'hf, channel_mb = 4'h2;
  logic [1:0]  rsp;
  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic        s_axi_arready, s_axi_rvalid;
  wire logic        split_active, config_invalid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int          failures, samples_checked, cycles;
  mem_cycle_if link ();
  split_controller split_controller_inst (.bus(link.proc), .*);
  board_memory_split_decoder board_memory_split_decoder_inst (
    .bus(link.board), .*);
  split_chk split_chk_inst (.aclk(aclk), .aresetn(aresetn),
    .cyc_valid(link.cyc_valid), .cyc_io(link.cyc_io),
    .cyc_addr(link.cyc_addr), .ans_valid(link.ans_valid),
    .ans_rdata(link.ans_rdata), .ans_target(link.ans_target));
  // clock, 20 ns period
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      final_report();
    end
  end
  // verdict and end of run
  task automatic final_report();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // axi write, address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  // axi read into st and rsp
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    st  = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // one processor cycle, then status once idle
  task automatic op(input logic io, wr, input logic [31:0] a,
                    input logic [7:0] d);
    axw(ADDR_OFS, a);
    axw(WDATA_OFS, {24'h0, d});
    axw(CTRL_OFS, {29'h0, wr, io, 1'b1});
    repeat (4) @(posedge aclk);
    do axr(STATUS_OFS); while (st[0] !== 1'b0);
  endtask
  task automatic mem(input logic [31:0] a, input target_e t);
    op(1'b0, 1'b0, a, 8'h00);
    `CHK(st[19:16], t)
  endtask
  task automatic ior(input logic [31:0] p, input logic [7:0] v);
    op(1'b1, 1'b0, p, 8'h00);
    `CHK(st[15:8], v)
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    ior(BASE, BASE_RESET);
    ior(ENC, ENC_RESET);
    mem(LOW512_END, TGT_NONE);
    mem(32'h00000000, TGT_LOW_RAM);
    mem(VIDEO_START, TGT_VIDEO);
    mem(CHROM_START, TGT_CHAN_ROM);
    mem(TOP_ROM_START, TGT_BOARD_ROM);
    mem(ROM_START, TGT_BOARD_ROM);
    mem(ONE_MB, TGT_EXT_RAM);
    mem(32'h003fffff, TGT_CHAN_RAM);
    mem(32'h00400000, TGT_NONE);
    mem(32'hfffdffff, TGT_NONE);
    op(1'b1, 1'b1, ENC, 8'h06);
    `CHK(config_invalid, 1'b1)
    `CHK(split_active, 1'b0)
    op(1'b1, 1'b1, BASE, 8'hf4);
    ior(BASE, 8'h04);
    `CHK(split_active, 1'b1)
    `CHK(config_invalid, 1'b0)
    mem(32'h00400000, TGT_SPLIT_RAM);
    mem(32'h0047ffff, TGT_SPLIT_RAM);
    mem(32'h00480000, TGT_NONE);
    op(1'b1, 1'b1, ENC, 8'h02);
    mem(32'h0009ffff, TGT_LOW_RAM);
    mem(32'h0045ffff, TGT_SPLIT_RAM);
    mem(32'h00460000, TGT_NONE);
    op(1'b1, 1'b1, BASE, 8'h0f);
    mem(32'h00f00000, TGT_SPLIT_RAM);
    op(1'b1, 1'b1, BASE, 8'h00);
    `CHK(st[2], 1'b1)
    op(1'b1, 1'b1, ENC, 8'h00);
    `CHK(st[2], 1'b1)
    op(1'b1, 1'b1, ENC, 8'h0c);
    mem(ROM_START, TGT_ROMSPACE_RAM);
    mem(32'hffffffff, TGT_BOARD_ROM);
    mem(32'h00f00000, TGT_NONE);
    mem_16m_or_more <= 1'b1;
    op(1'b1, 1'b1, ENC, 8'h06);
    `CHK(split_active, 1'b0)
    board_ext_mb <= 1'b0;
    channel_mb   <= 4'hf;
    mem(ONE_MB, TGT_CHAN_RAM);
    mem(32'h00ffffff, TGT_CHAN_RAM);
    mem(32'h01000000, TGT_NONE);
    ior(32'h00000050, IO_UNMAPPED);
    axr(8'h10);
    `CHK(rsp, RESP_SLVERR)
    final_report();
  end
endmodule
